// *** tcc_timer.sv ***
// sixteen-bit up/down counter with input capture, 8-bit register port
// assumes a master on the same clock; read data one cycle after strobe
`timescale 1ns/1ps
`include "tcc_consts.svh"

module tcc_timer #(
  parameter int PRE_W = 10
)
(
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // register port
  input  wire tcc_pkg::tcc_bus_t bus,
  output logic [7:0]            rdata,
  // external sources
  input  wire logic             external_tick_pin,
  input  wire logic             capture_pin,
  input  wire logic             comparator_output,
  // interrupt handshake
  input  wire logic             capture_irq_ack,
  input  wire logic             overflow_irq_ack,
  output logic                  capture_irq,
  output logic                  overflow_irq,
  // indications to the waveform side
  output logic                  at_top,
  output logic                  at_bottom,
  output logic [3:0]            waveform_mode_select
);

  logic [15:0]      cnt_reg, cnt_next;
  logic             down_reg, down_next;
  logic [7:0]       temp_reg, temp_next;
  logic [15:0]      cap_reg, cap_next;
  logic [15:0]      cmp_reg, cmp_next;
  logic [3:0]       mode_next;
  logic [2:0]       cs_reg, cs_next;
  logic             nf_reg, nf_next;
  logic             edge_reg, edge_next;
  logic             cmp_sel_reg, cmp_sel_next;
  logic             capf_reg, capf_next;
  logic             ovf_reg, ovf_next;
  logic             capie_reg, capie_next;
  logic             ovfie_reg, ovfie_next;
  logic [7:0]       rdata_next;
  logic [PRE_W-1:0] div_reg;
  logic [2:0]       ext_reg;
  logic             tick;
  logic             trig;
  logic             ovf_set;
  logic [15:0]      top;
  tcc_pkg::tcc_kind_t kind;

  // ****************************************************************
  // mode decoding
  // ****************************************************************
  function automatic tcc_pkg::tcc_kind_t kind_of(input logic [3:0] m);
    unique case (m)
      4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'hA, 4'hB: kind_of = tcc_pkg::KIND_PHASE;
      4'h5, 4'h6, 4'h7, 4'hE, 4'hF:           kind_of = tcc_pkg::KIND_FAST;
      4'h4, 4'hC:                             kind_of = tcc_pkg::KIND_CTC;
      default:                                kind_of = tcc_pkg::KIND_NORMAL;
    endcase
  endfunction

  function automatic logic cap_is_top(input logic [3:0] m);
    cap_is_top = (m == 4'h8) || (m == 4'hA) || (m == 4'hC) || (m == 4'hE);
  endfunction

  always_comb
  begin
    kind = kind_of(waveform_mode_select);
    unique case (waveform_mode_select)
      4'h1, 4'h5:               top = `TCC_TOP8;
      4'h2, 4'h6:               top = `TCC_TOP9;
      4'h3, 4'h7:               top = `TCC_TOP10;
      4'h4, 4'h9, 4'hB, 4'hF:   top = cmp_reg;
      4'h8, 4'hA, 4'hC, 4'hE:   top = cap_reg;
      default:                  top = `TCC_MAX;
    endcase
  end

  // ****************************************************************
  // timer tick: prescaler taps and external pin edges
  // ****************************************************************
  always_comb
  begin
    unique case (cs_reg)
      3'h1:    tick = 1'b1;
      3'h2:    tick = &div_reg[2:0];
      3'h3:    tick = &div_reg[5:0];
      3'h4:    tick = &div_reg[7:0];
      3'h5:    tick = &div_reg[9:0];
      `TCC_CS_EXT_FALL: tick = ext_reg[2] & ~ext_reg[1];
      `TCC_CS_EXT_RISE: tick = ~ext_reg[2] & ext_reg[1];
      default: tick = 1'b0;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      div_reg <= '0;
      ext_reg <= 3'h0;
    end
    else
    begin
      div_reg <= div_reg + 1'b1;
      ext_reg <= {ext_reg[1:0], external_tick_pin};
    end
  end

  // ****************************************************************
  // capture front end
  // ****************************************************************
  tcc_capture_front u_front (
    .clk                       (clk),
    .rst                       (rst),
    .capture_pin               (capture_pin),
    .comparator_output         (comparator_output),
    .comparator_capture_select (cmp_sel_reg),
    .noise_filter_enable       (nf_reg),
    .edge_rising               (edge_reg),
    .detect_enable             (!cap_is_top(waveform_mode_select)),
    .trig                      (trig)
  );

  // ****************************************************************
  // counter, registers and flags
  // ****************************************************************
  always_comb
  begin
    cnt_next   = cnt_reg;
    down_next  = down_reg;
    temp_next  = temp_reg;
    cap_next   = cap_reg;
    cmp_next   = cmp_reg;
    mode_next  = waveform_mode_select;
    cs_next    = cs_reg;
    nf_next    = nf_reg;
    edge_next  = edge_reg;
    cmp_sel_next = cmp_sel_reg;
    capie_next = capie_reg;
    ovfie_next = ovfie_reg;
    capf_next  = capf_reg;
    ovf_next   = ovf_reg;
    rdata_next = 8'h00;
    ovf_set    = 1'b0;
    // counting
    if (tick)
    begin
      if (kind == tcc_pkg::KIND_PHASE)
      begin
        if (down_reg && cnt_reg == `TCC_BOTTOM)
        begin
          down_next = 1'b0;
          cnt_next  = cnt_reg + 16'h0001;
          ovf_set   = 1'b1;
        end
        else if (!down_reg && cnt_reg == top)
        begin
          down_next = 1'b1;
          cnt_next  = cnt_reg - 16'h0001;
        end
        else
          cnt_next = down_reg ? cnt_reg - 16'h0001
                              : cnt_reg + 16'h0001;
      end
      else
      begin
        cnt_next = (cnt_reg == top) ? `TCC_BOTTOM
                                    : cnt_reg + 16'h0001;
        if (kind == tcc_pkg::KIND_FAST)
          ovf_set = (cnt_reg == top);
        else
          ovf_set = (cnt_reg == `TCC_MAX);
      end
    end
    // software writes
    if (bus.wr)
    begin
      unique case (bus.addr)
        `TCC_A_CNT_LO:
        begin
          cnt_next = {temp_reg, bus.wdata};
        end
        `TCC_A_CNT_HI, `TCC_A_CAP_HI, `TCC_A_CMP_HI:
          temp_next = bus.wdata;
        `TCC_A_CAP_LO:
          if (cap_is_top(waveform_mode_select))
            cap_next = {temp_reg, bus.wdata};
        `TCC_A_CMP_LO:
          cmp_next = {temp_reg, bus.wdata};
        `TCC_A_CTRL_A:
          mode_next[1:0] = bus.wdata[1:0];
        `TCC_A_CTRL_B:
        begin
          nf_next        = bus.wdata[`TCC_B_NF];
          edge_next      = bus.wdata[`TCC_B_EDGE];
          mode_next[3:2] = bus.wdata[`TCC_B_WGM_HI:`TCC_B_WGM_LO];
          cs_next        = bus.wdata[2:0];
        end
        `TCC_A_FLAGS:
        begin
          if (bus.wdata[`TCC_B_CAPF])
            capf_next = 1'b0;
          if (bus.wdata[`TCC_B_OVF])
            ovf_next = 1'b0;
        end
        `TCC_A_MASK:
        begin
          capie_next = bus.wdata[`TCC_B_CAPF];
          ovfie_next = bus.wdata[`TCC_B_OVF];
        end
        `TCC_A_CMP_CTRL:
          cmp_sel_next = bus.wdata[`TCC_B_CMPSEL];
        default: ;
      endcase
    end
    // software reads
    if (bus.rd)
    begin
      unique case (bus.addr)
        `TCC_A_CNT_LO:
        begin
          rdata_next = cnt_reg[7:0];
          temp_next  = cnt_reg[15:8];
        end
        `TCC_A_CAP_LO:
        begin
          rdata_next = cap_reg[7:0];
          temp_next  = cap_reg[15:8];
        end
        `TCC_A_CNT_HI, `TCC_A_CAP_HI:
          rdata_next = temp_reg;
        `TCC_A_CMP_LO: rdata_next = cmp_reg[7:0];
        `TCC_A_CMP_HI: rdata_next = cmp_reg[15:8];
        `TCC_A_CTRL_A: rdata_next = {6'h00, waveform_mode_select[1:0]};
        `TCC_A_CTRL_B:
          rdata_next = {nf_reg, edge_reg, 1'b0,
                        waveform_mode_select[3:2], cs_reg};
        `TCC_A_FLAGS:
          rdata_next = {2'h0, capf_reg, 2'h0, ovf_reg, 2'h0};
        `TCC_A_MASK:
          rdata_next = {2'h0, capie_reg, 2'h0, ovfie_reg, 2'h0};
        `TCC_A_CMP_CTRL: rdata_next = {5'h00, cmp_sel_reg, 2'h0};
        default:       rdata_next = 8'h00;
      endcase
    end
    // interrupt service clears; hardware sets win
    if (capture_irq_ack)
      capf_next = 1'b0;
    if (overflow_irq_ack)
      ovf_next = 1'b0;
    if (trig)
    begin
      cap_next  = cnt_reg;
      capf_next = 1'b1;
    end
    if (ovf_set)
      ovf_next = 1'b1;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cnt_reg              <= 16'h0000;
      down_reg             <= 1'b0;
      temp_reg             <= 8'h00;
      cap_reg              <= 16'h0000;
      cmp_reg              <= 16'h0000;
      waveform_mode_select <= 4'h0;
      cs_reg               <= `TCC_CS_STOP;
      nf_reg               <= 1'b0;
      edge_reg             <= 1'b0;
      cmp_sel_reg          <= 1'b0;
      capf_reg             <= 1'b0;
      ovf_reg              <= 1'b0;
      capie_reg            <= 1'b0;
      ovfie_reg            <= 1'b0;
      rdata                <= 8'h00;
      capture_irq          <= 1'b0;
      overflow_irq         <= 1'b0;
      at_top               <= 1'b0;
      at_bottom            <= 1'b1;
    end
    else
    begin
      cnt_reg              <= cnt_next;
      down_reg             <= down_next;
      temp_reg             <= temp_next;
      cap_reg              <= cap_next;
      cmp_reg              <= cmp_next;
      waveform_mode_select <= mode_next;
      cs_reg               <= cs_next;
      nf_reg               <= nf_next;
      edge_reg             <= edge_next;
      cmp_sel_reg          <= cmp_sel_next;
      capf_reg             <= capf_next;
      ovf_reg              <= ovf_next;
      capie_reg            <= capie_next;
      ovfie_reg            <= ovfie_next;
      rdata                <= rdata_next;
      capture_irq          <= capf_next & capie_next;
      overflow_irq         <= ovf_next & ovfie_next;
      at_top               <= (cnt_next == top);
      at_bottom            <= (cnt_next == `TCC_BOTTOM);
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  temp_load_a: assert property (
    bus.rd && bus.addr == `TCC_A_CNT_LO
    |=> temp_reg == $past(cnt_reg[15:8]) && rdata == $past(cnt_reg[7:0]))
    else $error("low read did not load holding byte");
  cnt_write_a: assert property (
    bus.wr && bus.addr == `TCC_A_CNT_LO
    |=> cnt_reg == {$past(temp_reg), $past(bus.wdata)})
    else $error("counter write lost to counting");
  stopped_a: assert property (
    cs_reg == `TCC_CS_STOP && !bus.wr |=> $stable(cnt_reg))
    else $error("counter moved while stopped");
  high_read_a: assert property (
    bus.rd && bus.addr == `TCC_A_CNT_HI |=> rdata == $past(temp_reg))
    else $error("high read bypassed holding byte");
  capture_a: assert property (
    trig |=> cap_reg == $past(cnt_reg) && capf_reg)
    else $error("capture copy or flag missing");
  flag_clear_a: assert property (
    bus.wr && bus.addr == `TCC_A_FLAGS && bus.wdata[`TCC_B_CAPF] && !trig
    |=> !capf_reg)
    else $error("capture flag not cleared");
  cmp_read_a: assert property (
    bus.rd && bus.addr == `TCC_A_CMP_HI |=> rdata == $past(cmp_reg[15:8]))
    else $error("compare high read wrong");
  cap_refuse_a: assert property (
    bus.wr && bus.addr == `TCC_A_CAP_LO && !trig
    && !cap_is_top(waveform_mode_select) |=> $stable(cap_reg))
    else $error("capture write taken in wrong mode");
  detect_off_a: assert property (
    cap_is_top(waveform_mode_select) ##1 cap_is_top(waveform_mode_select)
    |-> !trig)
    else $error("capture while capture register is ceiling");

  capture_seen_c:   cover property (trig ##1 capf_reg);
  overflow_seen_c:  cover property (ovf_set ##1 overflow_irq);
  turnaround_c:     cover property (!down_reg ##1 down_reg);

endmodule

// *** tcc_consts.svh ***
// constants of the sixteen-bit counter with input capture
// assumes an 8-bit register port with 4-bit byte addresses
`ifndef TCC_CONSTS_SVH
`define TCC_CONSTS_SVH

// ****************************************************************
// register byte addresses
// ****************************************************************
`define TCC_A_CNT_LO   4'h0
`define TCC_A_CNT_HI   4'h1
`define TCC_A_CAP_LO   4'h2
`define TCC_A_CAP_HI   4'h3
`define TCC_A_CMP_LO   4'h4
`define TCC_A_CMP_HI   4'h5
`define TCC_A_CTRL_A   4'h6
`define TCC_A_CTRL_B   4'h7
`define TCC_A_FLAGS    4'h8
`define TCC_A_MASK     4'h9
`define TCC_A_CMP_CTRL 4'hA

// ****************************************************************
// field positions
// ****************************************************************
`define TCC_B_NF       7
`define TCC_B_EDGE     6
`define TCC_B_WGM_HI   4
`define TCC_B_WGM_LO   3
`define TCC_B_CAPF     5
`define TCC_B_OVF      2
`define TCC_B_CMPSEL   2

// ****************************************************************
// values
// ****************************************************************
`define TCC_BOTTOM     16'h0000
`define TCC_MAX        16'hFFFF
`define TCC_TOP8       16'h00FF
`define TCC_TOP9       16'h01FF
`define TCC_TOP10      16'h03FF
`define TCC_CS_STOP    3'h0
`define TCC_CS_EXT_FALL 3'h6
`define TCC_CS_EXT_RISE 3'h7
`define TCC_NF_SAMPLES 4

`endif

// *** tcc_pkg.sv ***
// types shared by the counter, its cpu side model and the bench
// assumes nothing beyond the constants header
package tcc_pkg;

  // register port request
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } tcc_bus_t;

  // counting behaviour of a waveform mode
  typedef enum logic [1:0] {
    KIND_NORMAL,
    KIND_CTC,
    KIND_FAST,
    KIND_PHASE
  } tcc_kind_t;

endpackage

// *** tcc_capture_front.sv ***
// capture front end: synchronisers, source select, noise filter, edge
// assumes raw pin and comparator levels from outside the clock domain
`timescale 1ns/1ps
`include "tcc_consts.svh"

module tcc_capture_front
(
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // raw trigger sources
  input  wire logic capture_pin,
  input  wire logic comparator_output,
  // configuration
  input  wire logic comparator_capture_select,
  input  wire logic noise_filter_enable,
  input  wire logic edge_rising,
  input  wire logic detect_enable,
  // capture request, one cycle
  output logic      trig
);

  logic [1:0] pin_sync_reg;
  logic [1:0] cmp_sync_reg;
  logic [`TCC_NF_SAMPLES-1:0] hist_reg;
  logic [`TCC_NF_SAMPLES-1:0] hist_next;
  logic       lvl_reg;
  logic       lvl_next;
  logic       trig_next;
  logic       sample;

  // ****************************************************************
  // filter and edge detector
  // ****************************************************************
  always_comb
  begin
    sample    = comparator_capture_select ? cmp_sync_reg[1]
                                          : pin_sync_reg[1];
    hist_next = {hist_reg[`TCC_NF_SAMPLES-2:0], sample};
    lvl_next  = lvl_reg;
    if (!noise_filter_enable)
      lvl_next = sample;
    else if (&hist_reg || ~|hist_reg)
      lvl_next = hist_reg[`TCC_NF_SAMPLES-1];
    trig_next = detect_enable && (lvl_next != lvl_reg)
                && (lvl_next == edge_rising);
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      pin_sync_reg <= 2'h0;
      cmp_sync_reg <= 2'h0;
      hist_reg     <= '0;
      lvl_reg      <= 1'b0;
      trig         <= 1'b0;
    end
    else
    begin
      pin_sync_reg <= {pin_sync_reg[0], capture_pin};
      cmp_sync_reg <= {cmp_sync_reg[0], comparator_output};
      hist_reg     <= hist_next;
      lvl_reg      <= lvl_next;
      trig         <= trig_next;
    end
  end

endmodule

// *** tcc_cpu_model.sv ***
// cpu side model: byte register master and interrupt service
// assumes read data one cycle after the strobe, same clock as the timer
`timescale 1ns/1ps

module tcc_cpu_model
(
  // clock
  input  wire logic         clk,
  // register port
  output tcc_pkg::tcc_bus_t bus,
  input  wire logic [7:0]   rdata,
  // interrupt service
  output logic              cap_ack,
  output logic              ovf_ack
);
  initial
  begin
    bus = '0;
    cap_ack = 1'b0;
    ovf_ack = 1'b0;
  end

  // ****************************************************************
  // byte accesses
  // ****************************************************************
  task automatic wr8(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus <= '0;
  endtask

  task automatic rd8(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus <= '0;
    #1 d = rdata;
  endtask

  // ****************************************************************
  // sixteen-bit accesses, never split by interrupt service
  // ****************************************************************
  task automatic wr16(input logic [3:0] a, input logic [15:0] d);
    wr8(a + 4'h1, d[15:8]);
    wr8(a, d[7:0]);
  endtask

  task automatic rd16(input logic [3:0] a, output logic [15:0] d);
    rd8(a, d[7:0]);
    rd8(a + 4'h1, d[15:8]);
  endtask

  // interrupt service only between accesses
  task automatic serve(input logic cap);
    @(posedge clk);
    cap_ack <= cap;
    ovf_ack <= ~cap;
    @(posedge clk);
    cap_ack <= 1'b0;
    ovf_ack <= 1'b0;
  endtask
endmodule

// *** tb_sixteen_bit_counter_with_capture.sv ***
// self-checking bench of the sixteen-bit counter with capture
// assumes the cpu model drives the register port
`timescale 1ns/1ps
`include "tcc_consts.svh"

`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin num_errors++; \
  $display("Error %s expected %h seen %h", nm, e, g); end end

module tb_sixteen_bit_counter_with_capture;
  logic              clk;
  logic              rst;
  tcc_pkg::tcc_bus_t bus;
  logic [7:0]        rdata;
  logic              ext_pin;
  logic              cap_pin;
  logic              cmp_out;
  logic              cap_ack;
  logic              ovf_ack;
  logic              cap_irq;
  logic              ovf_irq;
  logic              at_top;
  logic              at_bottom;
  logic [3:0]        wms;
  logic [31:0]       seed;
  logic [15:0]       v;
  logic [15:0]       w;
  logic [7:0]        b;
  int                num_errors;
  int                checks;
  int                cycles;
  int                n0;
  int                n1;

  tcc_timer #(.PRE_W(10)) dut_u (.clk(clk), .rst(rst), .bus(bus),
    .rdata(rdata), .external_tick_pin(ext_pin), .capture_pin(cap_pin),
    .comparator_output(cmp_out), .capture_irq_ack(cap_ack),
    .overflow_irq_ack(ovf_ack), .capture_irq(cap_irq),
    .overflow_irq(ovf_irq), .at_top(at_top), .at_bottom(at_bottom),
    .waveform_mode_select(wms));

  tcc_cpu_model cpu_u (.clk(clk), .bus(bus), .rdata(rdata),
    .cap_ack(cap_ack), .ovf_ack(ovf_ack));

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction

  function automatic logic [15:0] ctc_step(input logic [15:0] c, t);
    return (c == t) ? 16'h0000 : c + 16'h0001;
  endfunction

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic ctrl(input logic [3:0] m, input logic nf, er,
                      input logic [2:0] cs);
    cpu_u.wr8(`TCC_A_CTRL_A, {6'h00, m[1:0]});
    cpu_u.wr8(`TCC_A_CTRL_B, {nf, er, 1'b0, m[3:2], cs});
  endtask

  task automatic ticks(input int n);
    repeat (n)
    begin
      @(posedge clk) ext_pin <= 1'b1;
      cyc(4);
      @(posedge clk) ext_pin <= 1'b0;
      cyc(4);
    end
    cyc(6);
  endtask

  task automatic pin(input logic p);
    @(posedge clk) cap_pin <= p;
  endtask

  task automatic cap_wait(output int n);
    n = 0;
    do
    begin
      @(posedge clk);
      #1 n++;
    end
    while (cap_irq !== 1'b1 && n < 40);
  endtask

  task automatic close_out();
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // ****************************************************************
  // clock and timeout
  // ****************************************************************
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      num_errors++;
      close_out();
    end
  end

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial
  begin
    rst = 1'b1;
    ext_pin = 1'b0;
    cap_pin = 1'b0;
    cmp_out = 1'b0;
    seed = 32'h001fc31c;
    cyc(16);
    rst <= 1'b0;
    @(posedge clk);
    #1 `CHK("at_bottom", 1'b1, at_bottom);
    `CHK("at_top", 1'b0, at_top);
    for (int m = 0; m < 16; m++)
    begin
      ctrl(m[3:0], 1'b0, 1'b1, 3'h0);
      cyc(2);
      `CHK("mode", m[3:0], wms);
    end
    ctrl(4'h0, 1'b0, 1'b1, 3'h0);
    repeat (8)
    begin
      seed = xs(seed);
      v = seed[15:0];
      cpu_u.wr16(`TCC_A_CNT_LO, v);
      cyc(3);
      cpu_u.rd16(`TCC_A_CNT_LO, w);
      `CHK("count", v, w);
    end
    // shared holding byte; compare high read bypasses it
    cpu_u.wr16(`TCC_A_CMP_LO, 16'hC3A5);
    cpu_u.wr8(`TCC_A_CNT_HI, 8'h5A);
    cpu_u.rd16(`TCC_A_CNT_LO, w);
    `CHK("count_hi_only", v, w);
    cpu_u.wr8(`TCC_A_CMP_HI, 8'h5A);
    cpu_u.wr8(`TCC_A_CNT_LO, 8'h11);
    cpu_u.rd16(`TCC_A_CNT_LO, w);
    `CHK("count_shared", 16'h5A11, w);
    cpu_u.rd8(`TCC_A_CMP_HI, b);
    `CHK("cmp_hi", 8'hC3, b);
    // software write beats counting
    cpu_u.wr16(`TCC_A_CNT_LO, 16'h8000);
    ctrl(4'h0, 1'b0, 1'b1, 3'h1);
    cpu_u.wr16(`TCC_A_CNT_LO, 16'h1000);
    ctrl(4'h0, 1'b0, 1'b1, 3'h0);
    cpu_u.rd16(`TCC_A_CNT_LO, w);
    `CHK("write_prio", 1'b1, (w >= 16'h1000 && w < 16'h1010));
    // external ticks across maximum
    ctrl(4'h0, 1'b0, 1'b1, `TCC_CS_EXT_RISE);
    cpu_u.wr16(`TCC_A_CNT_LO, 16'hFFFE);
    ticks(1);
    `CHK("at_top_max", 1'b1, at_top);
    ticks(1);
    `CHK("at_bottom_wrap", 1'b1, at_bottom);
    cpu_u.rd8(`TCC_A_FLAGS, b);
    `CHK("ovf_flag", 1'b1, b[`TCC_B_OVF]);
    ticks(1);
    cpu_u.rd16(`TCC_A_CNT_LO, w);
    `CHK("count_ext", 16'h0001, w);
    cpu_u.wr8(`TCC_A_MASK, 8'h04);
    cyc(3);
    `CHK("ovf_irq", 1'b1, ovf_irq);
    cpu_u.serve(1'b0);
    cyc(3);
    `CHK("ovf_irq_ack", 1'b0, ovf_irq);
    // compare ceiling clears the counter
    ctrl(4'h4, 1'b0, 1'b1, `TCC_CS_EXT_RISE);
    cpu_u.wr16(`TCC_A_CMP_LO, 16'h0003);
    cpu_u.wr16(`TCC_A_CNT_LO, 16'h0000);
    v = 16'h0000;
    repeat (5) v = ctc_step(v, 16'h0003);
    ticks(5);
    cpu_u.rd16(`TCC_A_CNT_LO, w);
    `CHK("count_ctc", v, w);
    // phase mode turns at its fixed top, falling pin edges
    ctrl(4'h1, 1'b0, 1'b1, `TCC_CS_EXT_FALL);
    cpu_u.wr16(`TCC_A_CNT_LO, 16'h00FE);
    ticks(3);
    cpu_u.rd16(`TCC_A_CNT_LO, w);
    `CHK("count_phase", 16'h00FD, w);
    // capture on rising pin edge
    ctrl(4'h0, 1'b0, 1'b1, 3'h0);
    seed = xs(seed);
    v = seed[15:0];
    cpu_u.wr16(`TCC_A_CNT_LO, v);
    cpu_u.wr8(`TCC_A_MASK, 8'h20);
    cpu_u.wr8(`TCC_A_FLAGS, 8'h20);
    pin(1'b1);
    cap_wait(n0);
    `CHK("cap_irq", 1'b1, cap_irq);
    cpu_u.rd8(`TCC_A_FLAGS, b);
    `CHK("cap_flag", 1'b1, b[`TCC_B_CAPF]);
    cpu_u.rd16(`TCC_A_CAP_LO, w);
    `CHK("capture", v, w);
    cpu_u.wr8(`TCC_A_FLAGS, 8'h00);
    cpu_u.rd8(`TCC_A_FLAGS, b);
    `CHK("flag_zero_wr", 1'b1, b[`TCC_B_CAPF]);
    cpu_u.wr8(`TCC_A_FLAGS, 8'h20);
    cpu_u.rd8(`TCC_A_FLAGS, b);
    `CHK("flag_one_wr", 1'b0, b[`TCC_B_CAPF]);
    // falling edge overwrites the earlier captured value
    seed = xs(seed);
    v = seed[15:0];
    cpu_u.wr16(`TCC_A_CNT_LO, v);
    ctrl(4'h0, 1'b0, 1'b0, 3'h0);
    cpu_u.wr8(`TCC_A_FLAGS, 8'h20);
    pin(1'b0);
    cap_wait(n1);
    cpu_u.rd16(`TCC_A_CAP_LO, w);
    `CHK("capture_fall", v, w);
    // filter latency and glitch rejection
    ctrl(4'h0, 1'b1, 1'b1, 3'h0);
    cpu_u.wr8(`TCC_A_FLAGS, 8'h20);
    pin(1'b1);
    cap_wait(n1);
    `CHK("filter_delay", 4, n1 - n0);
    ctrl(4'h0, 1'b1, 1'b0, 3'h0);
    cpu_u.wr8(`TCC_A_FLAGS, 8'h20);
    pin(1'b0);
    cyc(2);
    pin(1'b1);
    cyc(15);
    `CHK("glitch", 1'b0, cap_irq);
    pin(1'b0);
    cap_wait(n1);
    `CHK("filtered_cap", 1'b1, cap_irq);
    cpu_u.serve(1'b1);
    cyc(3);
    `CHK("cap_irq_ack", 1'b0, cap_irq);
    // comparator as trigger source
    ctrl(4'h0, 1'b0, 1'b1, 3'h0);
    cpu_u.wr8(`TCC_A_CMP_CTRL, 8'h04);
    cpu_u.wr8(`TCC_A_FLAGS, 8'h20);
    pin(1'b1);
    cyc(15);
    `CHK("pin_ignored", 1'b0, cap_irq);
    @(posedge clk) cmp_out <= 1'b1;
    cap_wait(n1);
    `CHK("cmp_capture", 1'b1, cap_irq);
    cpu_u.wr8(`TCC_A_CMP_CTRL, 8'h00);
    // capture register as ceiling
    ctrl(4'hC, 1'b0, 1'b1, 3'h0);
    cpu_u.wr16(`TCC_A_CAP_LO, 16'h0123);
    cpu_u.rd16(`TCC_A_CAP_LO, w);
    `CHK("cap_write", 16'h0123, w);
    cpu_u.wr16(`TCC_A_CNT_LO, 16'h0123);
    cyc(3);
    `CHK("at_top_cap", 1'b1, at_top);
    pin(1'b0);
    cyc(10);
    cpu_u.wr8(`TCC_A_FLAGS, 8'h20);
    pin(1'b1);
    cyc(15);
    `CHK("cap_off", 1'b0, cap_irq);
    ctrl(4'h0, 1'b0, 1'b1, 3'h0);
    cpu_u.wr16(`TCC_A_CAP_LO, 16'hBEEF);
    cpu_u.rd16(`TCC_A_CAP_LO, w);
    `CHK("cap_write_refused", 16'h0123, w);
    close_out();
  end
endmodule
